// *** opdec_regs.vh ***
/*
 * Constants for the three-instruction execution block: opcode patterns, field
 * positions, phase codes and reset values.
 * Assumes 14-bit program words and an 8-bit data path with 7-bit file addresses.
 */
`ifndef OPDEC_REGS_VH
`define OPDEC_REGS_VH

`define OP_INC_SKIP_HI 6'h0f
`define OP_OR_FILE_HI 6'h04
`define OP_OR_LIT_HI 6'h38
`define OP_HI_MSB 13
`define OP_HI_LSB 8
`define DIR_BIT 7
`define FADDR_MSB 6
`define LIT_MSB 7

`define PH_Q1 2'h0
`define PH_Q2 2'h1
`define PH_Q3 2'h2
`define PH_Q4 2'h3

`define W_RESET 8'h00
`define Z_RESET 1'h0

`endif

// *** opdec_alu.v ***
/*
 * Combinational data unit for the increment and the two OR operations.
 * Assumes the caller holds the operands steady through the process phase.
 */
`timescale 1ns/1ns
module opdec_alu (
  input wire i_sel_inc,
  input wire [7:0] i_w,
  input wire [7:0] i_b,
  output wire [7:0] o_res,
  output wire o_zero
);
  // An all-ones operand wraps to zero, which is what triggers the skip.
  assign o_res = i_sel_inc ? i_b + 8'h01 : (i_w | i_b); // [RULE_06]
  assign o_zero = (o_res == 8'h00);
endmodule // opdec_alu

// *** opdec_core.v ***
/*
 * Execution of increment-and-skip-if-zero, OR literal into accumulator and
 * OR accumulator with file register over a four-phase instruction cycle.
 * Assumes the instruction word is valid at the Q1 edge and the file read
 * data answers the address combinationally in the same cycle.
 */
// Behaviour
// RULE_01 - Increment-skip adds one to file register; d picks W or file; no flags.
// RULE_02 - Zero result turns the next instruction into a two-cycle all-idle no-op; the code idles it for one four-phase cycle.
// RULE_03 - OR literal ORs W with low eight opcode bits into W; zero flag updated.
// RULE_04 - OR file ORs W with file register, d picks destination, zero flag updated.
// RULE_05 - OR instructions take one word, one cycle: decode, read, process, write.
// RULE_06 - Increment wraps modulo 256, so all-ones becomes zero and skips.
`timescale 1ns/1ns
`include "opdec_regs.vh"
module opdec_core (
  input wire i_clk_sys,
  input wire i_reset,
  input wire [13:0] i_instr,
  input wire [7:0] i_file_rdata,
  output wire [1:0] o_phase,
  output wire o_instr_take,
  output reg [6:0] o_file_addr,
  output reg o_file_we,
  output reg [7:0] o_file_wdata,
  output reg [7:0] o_w,
  output reg o_zero_flag,
  output reg o_skip_active,
  output reg o_illegal
);
  // A skip slot is the only other state; it idles through all four phases.
  localparam ST_RUN = 1'b0;
  localparam ST_SKIP = 1'b1;

  // Every internal register has its next value computed in one place below.
  reg [1:0] phase_r;
  reg [1:0] phase_nxt;
  reg state_r;
  reg state_nxt;
  reg skip_pend_r;
  reg skip_pend_nxt;
  reg [13:0] ir_r;
  reg [13:0] ir_nxt;
  reg [7:0] opnd_r;
  reg [7:0] opnd_nxt;
  reg [7:0] res_r;
  reg [7:0] res_nxt;
  reg zero_r;
  reg zero_nxt;
  reg [6:0] file_addr_nxt;
  reg file_we_nxt;
  reg [7:0] file_wdata_nxt;
  reg [7:0] w_nxt;
  reg zero_flag_nxt;
  reg skip_active_nxt;
  reg illegal_nxt;
  wire [5:0] op_hi;
  wire [5:0] in_op_hi;
  wire is_inc;
  wire is_or_file;
  wire is_or_lit;
  wire in_legal;
  wire dir_file;
  wire writes_flag;
  wire [7:0] alu_res;
  wire alu_zero;

  // Opcode match on the six high bits, for the held word and the incoming one.
  function is_op;
    input [5:0] hi;
    input [5:0] pat;
    begin
      is_op = (hi == pat);
    end
  endfunction

  assign op_hi = ir_r[`OP_HI_MSB:`OP_HI_LSB];
  assign in_op_hi = i_instr[`OP_HI_MSB:`OP_HI_LSB];
  assign is_inc = is_op(op_hi, `OP_INC_SKIP_HI);
  assign is_or_file = is_op(op_hi, `OP_OR_FILE_HI);
  assign is_or_lit = is_op(op_hi, `OP_OR_LIT_HI);
  assign in_legal = is_op(in_op_hi, `OP_INC_SKIP_HI) || is_op(in_op_hi, `OP_OR_FILE_HI) ||
    is_op(in_op_hi, `OP_OR_LIT_HI);
  assign dir_file = ir_r[`DIR_BIT];
  assign writes_flag = is_or_lit || is_or_file;
  assign o_phase = phase_r;
  assign o_instr_take = (phase_r == `PH_Q1);

  opdec_alu u_alu (
    .i_sel_inc(is_inc),
    .i_w(o_w),
    .i_b(opnd_r),
    .o_res(alu_res),
    .o_zero(alu_zero)
  );

  // Next-state logic; the phase counter advances and the write strobe clears, every other register holds unless its phase says otherwise.
  always @* begin
    phase_nxt = phase_r + 2'h1;
    state_nxt = state_r;
    skip_pend_nxt = skip_pend_r;
    ir_nxt = ir_r;
    opnd_nxt = opnd_r;
    res_nxt = res_r;
    zero_nxt = zero_r;
    file_addr_nxt = o_file_addr;
    file_we_nxt = 1'b0;
    file_wdata_nxt = o_file_wdata;
    w_nxt = o_w;
    zero_flag_nxt = o_zero_flag;
    skip_active_nxt = o_skip_active;
    illegal_nxt = o_illegal;
    case (phase_r)
      `PH_Q1: begin
        if (skip_pend_r) begin // [RULE_02]
          // The skipped word is dropped, yet the slot still costs four phases.
          state_nxt = ST_SKIP;
          skip_active_nxt = 1'b1;
          skip_pend_nxt = 1'b0;
          ir_nxt = 14'h0000;
        end else begin // [RULE_05]
          state_nxt = ST_RUN;
          skip_active_nxt = 1'b0;
          ir_nxt = i_instr;
          file_addr_nxt = i_instr[`FADDR_MSB:0];
          illegal_nxt = !in_legal;
        end
      end
      `PH_Q2: begin
        case (state_r)
          ST_RUN: begin
            if (is_or_lit) begin
              opnd_nxt = ir_r[`LIT_MSB:0]; // [RULE_03]
            end else begin
              opnd_nxt = i_file_rdata; // [RULE_01] [RULE_04]
            end
          end
          default: begin
            opnd_nxt = opnd_r;
          end
        endcase
      end
      `PH_Q3: begin
        case (state_r)
          ST_RUN: begin
            res_nxt = alu_res; // [RULE_05] [RULE_06]
            zero_nxt = alu_zero;
          end
          default: begin
            res_nxt = res_r;
          end
        endcase
      end
      `PH_Q4: begin
        case (state_r)
          ST_RUN: begin
            if (is_inc) begin
              skip_pend_nxt = zero_r; // [RULE_02]
            end
            if (is_or_lit) begin
              w_nxt = res_r; // [RULE_03]
            end else if (is_or_file || is_inc) begin
              if (dir_file) begin
                file_we_nxt = 1'b1; // [RULE_01] [RULE_04]
                file_wdata_nxt = res_r;
              end else begin
                w_nxt = res_r;
              end
            end
            // Increment-skip leaves the flag alone even when it wraps to zero.
            if (writes_flag) begin
              zero_flag_nxt = zero_r; // [RULE_03] [RULE_04]
            end
          end
          ST_SKIP: begin
            // An idle slot writes nothing and can never arm a further skip.
            file_we_nxt = 1'b0; // [RULE_02]
            skip_pend_nxt = 1'b0;
          end
          default: begin
            state_nxt = ST_RUN;
          end
        endcase
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // The reset branch loads constants only, so the release edge is clean.
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      phase_r <= `PH_Q1;
      state_r <= ST_RUN;
      skip_pend_r <= 1'b0;
      ir_r <= 14'h0000;
      opnd_r <= 8'h00;
      res_r <= 8'h00;
      zero_r <= 1'b0;
      o_file_addr <= 7'h00;
      o_file_we <= 1'b0;
      o_file_wdata <= 8'h00;
      o_w <= `W_RESET;
      o_zero_flag <= `Z_RESET;
      o_skip_active <= 1'b0;
      o_illegal <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      state_r <= state_nxt;
      skip_pend_r <= skip_pend_nxt;
      ir_r <= ir_nxt;
      opnd_r <= opnd_nxt;
      res_r <= res_nxt;
      zero_r <= zero_nxt;
      o_file_addr <= file_addr_nxt;
      o_file_we <= file_we_nxt;
      o_file_wdata <= file_wdata_nxt;
      o_w <= w_nxt;
      o_zero_flag <= zero_flag_nxt;
      o_skip_active <= skip_active_nxt;
      o_illegal <= illegal_nxt;
    end
  end
endmodule // opdec_core

// *** opdec_core_asserts.sv ***
/* Checker for the opdec_core port timing.
   Assumes it is bound to opdec_core and sees only its ports. */
`timescale 1ns/1ns
module opdec_core_asserts (
  input wire i_clk_sys,
  input wire i_reset,
  input wire [1:0] o_phase,
  input wire o_file_we,
  input wire [7:0] o_file_wdata,
  input wire [7:0] o_w,
  input wire o_zero_flag,
  input wire o_skip_active
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  a_phase_wrap: assert property (o_phase == 2'h3 |=> o_phase == 2'h0)
    else $error("phase did not wrap");
  a_w_hold: assert property (o_phase != 2'h0 |-> $stable(o_w))
    else $error("W moved mid cycle");
  a_z_hold: assert property (o_phase != 2'h0 |-> $stable(o_zero_flag))
    else $error("Z moved mid cycle");
  a_we_pulse: assert property (o_file_we |-> o_phase == 2'h0 ##1 !o_file_we)
    else $error("file write pulse wrong");
  a_skip_len: assert property ($rose(o_skip_active) |-> o_skip_active [*4] ##1 !o_skip_active)
    else $error("skip slot length wrong");
  a_skip_zero: assert property ($rose(o_skip_active) |->
    ($past(o_file_we) ? $past(o_file_wdata) : o_w) == 8'h00)
    else $error("skip without zero result");
  a_skip_quiet: assert property (o_skip_active && o_phase == 2'h3 |=>
    !o_file_we && $stable(o_w))
    else $error("skip slot wrote");
  c_skip: cover property ($rose(o_skip_active));
  c_fwrite: cover property (o_file_we);
  c_zero: cover property ($rose(o_zero_flag));
endmodule // opdec_core_asserts
bind opdec_core opdec_core_asserts u_chk (.i_clk_sys, .i_reset, .o_phase, .o_file_we,
  .o_file_wdata, .o_w, .o_zero_flag, .o_skip_active);

// *** increment_skip_and_or_ops_tb.sv ***
/* Self-checking bench for opdec_core.
   Assumes one instruction per four clocks, taken at the first edge after reset. */
`timescale 1ns/1ns
module increment_skip_and_or_ops_tb;
  reg i_clk_sys, i_reset;
  reg [13:0] i_instr;
  reg [7:0] i_file_rdata;
  wire [1:0] o_phase;
  wire [6:0] o_file_addr;
  wire [7:0] o_file_wdata, o_w;
  wire o_instr_take, o_file_we, o_zero_flag, o_skip_active, o_illegal;
  integer err_total = 0, comparisons = 0;
  opdec_core u_dut (.i_clk_sys, .i_reset, .i_instr, .i_file_rdata, .o_phase, .o_instr_take,
    .o_file_addr, .o_file_we, .o_file_wdata, .o_w, .o_zero_flag, .o_skip_active, .o_illegal);
  task x(input [13:0] i, input [7:0] r);
    begin
      i_instr = i;
      i_file_rdata = r;
      repeat (4) @(negedge i_clk_sys);
    end
  endtask
  task ck(input [15:0] g, input [15:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("[ERR] %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task t_inc;
    begin
      x(14'h3800, 8'h00);
      ck({o_zero_flag, o_w}, 9'h100);
      x(14'h0f03, 8'h41);
      ck({o_zero_flag, o_w}, 9'h142);
      x(14'h3801, 8'h00);
      ck({o_zero_flag, o_w}, 9'h043);
      x(14'h0f83, 8'hff);
      ck({o_file_we, o_file_wdata}, 9'h100);
      ck({o_skip_active, o_zero_flag, o_w}, 10'h043);
      x(14'h38ff, 8'h00);
      ck({o_skip_active, o_file_we, o_w}, 10'h243);
      x(14'h0f05, 8'hff);
      ck({o_skip_active, o_zero_flag, o_w}, 10'h000);
      x(14'h3822, 8'h00);
      ck({o_skip_active, o_zero_flag, o_w}, 10'h200);
      x(14'h3842, 8'h00);
      ck({o_skip_active, o_zero_flag, o_w}, 10'h042);
      $display("increment test done");
    end
  endtask
  task t_or;
    begin
      x(14'h3805, 8'h00);
      ck({o_zero_flag, o_w}, 9'h047);
      x(14'h0418, 8'h88);
      ck({o_zero_flag, o_w}, 9'h0cf);
      x(14'h0490, 8'h30);
      ck({o_file_we, o_file_wdata}, 9'h1ff);
      ck({o_file_we, o_w}, 9'h1cf);
      ck({o_file_addr, o_zero_flag}, 8'h20);
      ck({o_instr_take, o_phase}, 3'h4);
      $display("or test done");
    end
  endtask
  task t_bad;
    begin
      x(14'h2a55, 8'h0f);
      ck({o_illegal, o_file_we, o_zero_flag, o_w}, 11'h4cf);
      x(14'h3800, 8'h00);
      ck({o_illegal, o_zero_flag, o_w}, 10'h0cf);
      $display("unknown opcode test done");
    end
  endtask
  task t_reset;
    begin
      i_reset = 1'b1;
      repeat (2) @(negedge i_clk_sys);
      ck({o_phase, o_illegal, o_skip_active, o_file_we, o_zero_flag, o_w}, 14'h0000);
      i_reset = 1'b0;
      x(14'h3833, 8'h00);
      ck({o_zero_flag, o_w}, 9'h033);
      $display("reset test done");
    end
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    #20000;
    err_total = err_total + 1;
    close_out;
  end
  initial begin
    i_reset = 1'b1;
    i_instr = 14'h0000;
    i_file_rdata = 8'h00;
    repeat (6) @(negedge i_clk_sys);
    i_reset = 1'b0;
    t_inc;
    t_or;
    t_bad;
    t_reset;
    close_out;
  end
endmodule // increment_skip_and_or_ops_tb
